// File: verification/ebc_checker.sv
// checker: port-level assertions for the endpoint buffer control block
`timescale 1ns/1ps
`default_nettype none
module ebc_checker import ebc_pkg::*; #(
	parameter int EP_NUM = EBC_EP_NUM
) (
	// clock and reset
	input wire logic                clk,
	input wire logic                rst,
	input wire logic                usb_bus_rst,
	// bus
	input wire logic [7:0]          avs_address,
	input wire logic                avs_read,
	input wire logic                avs_write,
	input wire logic [31:0]         avs_writedata,
	input wire logic [31:0]         avs_readdata,
	input wire logic                avs_waitrequest,
	// endpoint and link
	input wire logic [2*EP_NUM-1:0] ep_isochronous,
	input wire ebc_link_evt_t       link_evt,
	// outputs
	input wire logic                flush_pulse,
	input wire logic                commit_pulse,
	input wire logic [EBC_EP_W:0]   cmd_slot,
	input wire logic                ctl_data_nak,
	input wire logic                ctl_status_ack,
	input wire logic [2*EP_NUM-1:0] ep_stalled
);
	// ****
	// assertions
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire ctl_wr = avs_write && avs_address == EBC_ADDR_CTRL;
	wire ep0_evt = link_evt.ep == 4'h0 && !avs_write;
	sequence req_rise_s; $rose(avs_read || avs_write); endsequence
	sequence answer_s; ##[1:3] !avs_waitrequest; endsequence
	wait_answer_a: assert property (req_rise_s |-> answer_s) else $error("no bus answer");
	wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
	flush_cause_a: assert property (
		flush_pulse |-> $past(ctl_wr && avs_writedata[EBC_BIT_FLUSH])) else $error("bad flush");
	commit_in_a: assert property (
		commit_pulse |-> $past(ctl_wr && avs_writedata[EBC_BIT_COMMIT]) && cmd_slot[0])
		else $error("bad commit");
	pulse_once_a: assert property (
		flush_pulse || commit_pulse |=> !flush_pulse && !commit_pulse) else $error("long pulse");
	permit_read_a: assert property (
		avs_read && !avs_waitrequest && avs_address == EBC_ADDR_CTRL
		|-> avs_readdata[7:5] == 3'h0 && !avs_readdata[EBC_BIT_PERMIT]) else $error("bad read");
	permit_clear_a: assert property (
		link_evt.data_ack && ep0_evt |-> ##[1:2] ctl_data_nak) else $error("permit kept");
	status_clear_a: assert property (
		(link_evt.status_done || link_evt.setup_tok) && ep0_evt |-> ##[1:2] !ctl_status_ack)
		else $error("status kept");
	bus_reset_a: assert property (
		usb_bus_rst && !avs_write |-> ##[1:2] ctl_data_nak && !ctl_status_ack && ep_stalled == '0)
		else $error("bus reset missed");
	iso_stall_a: assert property (
		(ep_stalled & ~$past(ep_stalled) & ep_isochronous) == '0) else $error("iso stalled");
endmodule
bind ebc_top ebc_checker #(.EP_NUM(EP_NUM)) u_chk (.*);
`default_nettype wire

// File: verification/ebc_host_model.sv
// host model: issues setup, data and status events toward endpoint 0
`timescale 1ns/1ps
`default_nettype none
module ebc_host_model import ebc_pkg::*; (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// command from the bench
	input wire logic       go,
	input wire logic [1:0] kind,
	input wire logic [3:0] gap,
	// link events
	output var ebc_link_evt_t link_evt
);
	// ****
	// token sequencer
	// ****
	logic [3:0] wait_r;
	logic       busy_r;
	logic [1:0] kind_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
			wait_r <= 4'h0;
			kind_r <= 2'h0;
			link_evt <= '0;
		end else begin
			link_evt.setup_tok <= 1'b0;
			link_evt.status_done <= 1'b0;
			link_evt.data_ack <= 1'b0;
			// endpoint field wanders outside events
			link_evt.ep <= link_evt.ep + 4'h1;
			if (go) begin
				busy_r <= 1'b1;
				wait_r <= gap;
				kind_r <= kind;
			end else if (busy_r && wait_r != 4'h0) begin
				wait_r <= wait_r - 4'h1;
			end else if (busy_r) begin
				busy_r <= 1'b0;
				link_evt.ep <= 4'h0;
				link_evt.setup_tok <= kind_r == 2'h0;
				link_evt.data_ack <= kind_r == 2'h1;
				link_evt.status_done <= kind_r == 2'h2;
			end
		end
	end
endmodule
`default_nettype wire

// File: verification/tb.sv
// testbench: random and directed control register traffic with a host model
`timescale 1ns/1ps
`default_nettype none
module tb import ebc_pkg::*;;
	logic          clk, rst, usb_bus_rst, avs_read, avs_write, avs_waitrequest, go;
	logic          flush_pulse, commit_pulse, ctl_data_nak, ctl_status_ack;
	logic [7:0]    avs_address, sel, d;
	logic [31:0]   avs_writedata, avs_readdata, q;
	logic [15:0]   ep_enabled, ep_isochronous, ep_full_packet, ep_rx_drained, ep_stalled, stall_m;
	logic [4:0]    cmd_slot, last_slot;
	logic [1:0]    kind;
	logic [3:0]    gap;
	ebc_link_evt_t link_evt;
	int            err_total, total_checks, fl_n, cm_n, f0, c0, seed;
	ebc_top #(.EP_NUM(8)) dut (.*);
	ebc_host_model host_i (.clk(clk), .rst(rst), .go(go), .kind(kind), .gap(gap), .link_evt(link_evt));
	// ****
	// helpers
	// ****
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (flush_pulse === 1'b1 || commit_pulse === 1'b1) begin
			fl_n = fl_n + int'(flush_pulse);
			cm_n = cm_n + int'(commit_pulse);
			last_slot = cmd_slot;
		end
	end
	function automatic logic takes(input logic [7:0] s);
		return !s[4] && ep_enabled[s[3:0]] && !s[EBC_SEL_SETUP];
	endfunction
	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] v);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h000000, v};
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		q = avs_readdata;
		if (avs_waitrequest !== 1'b0)
			err_total++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic host_ev(input logic [1:0] k, input logic [3:0] g);
		go <= 1'b1;
		kind <= k;
		gap <= g;
		@(posedge clk);
		go <= 1'b0;
		repeat (int'(g) + 5) @(posedge clk);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_of_test;
	end
	// ****
	// tests
	// ****
	initial begin
		seed = 2;
		{err_total, total_checks, fl_n, cm_n} = '0;
		{rst, usb_bus_rst, avs_read, avs_write, go, kind, gap} = 11'h400;
		{avs_address, avs_writedata, stall_m, last_slot} = '0;
		ep_enabled = 16'($random(seed)) | 16'h0003;
		ep_isochronous = 16'($random(seed)) & 16'hFFFC;
		ep_full_packet = 16'($random(seed));
		ep_rx_drained = 16'($random(seed));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(0, EBC_ADDR_SEL, 8'h00);
		chk(q, {24'h0, EBC_SEL_RST});
		bus(0, EBC_ADDR_CTRL, 8'h00);
		chk(q, 32'h0);
		chk({ctl_data_nak, ctl_status_ack, ep_stalled}, 18'h20000);
		bus(1, 8'h00, 8'hFF);
		bus(0, 8'h00, 8'h00);
		chk(q, 32'h0);
		bus(0, EBC_ADDR_STAT, 8'h00);
		chk(q & 32'h6, {29'h0, |ep_full_packet, |ep_rx_drained, 1'b0});
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			sel = 8'($random(seed)) & 8'h3F;
			d = 8'($random(seed)) & 8'h19;
			{f0, c0} = {fl_n, cm_n};
			bus(1, EBC_ADDR_SEL, sel);
			bus(1, EBC_ADDR_CTRL, d);
			if (takes(sel) && !ep_isochronous[sel[3:0]])
				stall_m[sel[3:0]] = d[EBC_BIT_STALL];
			chk(32'(fl_n - f0), 32'(takes(sel) && d[4]));
			chk(32'(cm_n - c0), 32'(takes(sel) && d[3] && sel[0]));
			if (fl_n != f0 || cm_n != c0)
				chk(32'(last_slot), 32'(sel[4:0]));
			chk(32'(ep_stalled), 32'(stall_m));
			bus(0, EBC_ADDR_CTRL, 8'h00);
			if (!sel[EBC_SEL_SETUP])
				chk(q & 32'hE5, 32'(stall_m[sel[3:0]] && !sel[4]));
		end
		$display("test random commands done");
		bus(1, EBC_ADDR_SEL, 8'h00);
		host_ev(2'h0, 4'h0);
		chk(32'(ctl_data_nak), 32'h1);
		bus(1, EBC_ADDR_CTRL, 8'h04);
		chk(32'(ctl_data_nak), 32'h0);
		bus(0, EBC_ADDR_CTRL, 8'h00);
		chk(q & 32'h4, 32'h0);
		host_ev(2'h1, 4'h9);
		chk(32'(ctl_data_nak), 32'h1);
		bus(1, EBC_ADDR_CTRL, 8'h02);
		chk(32'(ctl_status_ack), 32'h1);
		host_ev(2'h2, 4'h0);
		chk(32'(ctl_status_ack), 32'h0);
		bus(1, EBC_ADDR_CTRL, 8'h06);
		host_ev(2'h0, 4'h3);
		chk({30'h0, ctl_status_ack, ctl_data_nak}, 32'h1);
		host_ev(2'h0, 4'h0);
		bus(1, EBC_ADDR_CTRL, 8'h02);
		chk(32'(ctl_status_ack), 32'h1);
		{f0, c0} = {fl_n, cm_n};
		bus(1, EBC_ADDR_SEL, 8'h01);
		bus(1, EBC_ADDR_CTRL, 8'h04);
		bus(1, EBC_ADDR_CTRL, 8'h08);
		chk(32'(cm_n - c0), 32'h1);
		bus(1, EBC_ADDR_CTRL, 8'h10);
		bus(1, EBC_ADDR_CTRL, 8'h10);
		chk(32'(fl_n - f0), 32'h2);
		$display("test control stages done");
		bus(1, EBC_ADDR_SEL, 8'h01);
		bus(1, EBC_ADDR_CTRL, 8'h07);
		ep_enabled[1] <= 1'b0;
		@(posedge clk);
		ep_enabled[1] <= 1'b1;
		@(posedge clk);
		chk(32'(ep_stalled[1]), 32'h1);
		bus(1, EBC_ADDR_SEL, 8'h23);
		usb_bus_rst <= 1'b1;
		@(posedge clk);
		usb_bus_rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk({ctl_data_nak, ctl_status_ack, ep_stalled}, 18'h20000);
		bus(0, EBC_ADDR_SEL, 8'h00);
		chk(q, 32'h20);
		$display("test bus reset done");
		end_of_test;
	end
endmodule
`default_nettype wire

// File: verilog/ebc_flag_bank.sv
// per-endpoint flag memory: one set/clear bit per endpoint slot, registered read
`timescale 1ns/1ps
`default_nettype none
module ebc_flag_bank import ebc_pkg::*; #(
	parameter int SLOTS = 2*EBC_EP_NUM
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     bus_rst,
	// firmware side
	input  wire logic [$clog2(SLOTS)-1:0] fw_slot,
	input  wire logic                     fw_set,
	input  wire logic                     fw_clr,
	// hardware side
	input  wire logic [$clog2(SLOTS)-1:0] hw_slot,
	input  wire logic                     hw_clr,
	// read port
	input  wire logic [$clog2(SLOTS)-1:0] rd_slot,
	output logic                          rd_data,
	output logic [SLOTS-1:0]              flags
);
	logic [SLOTS-1:0] flags_r;
	logic             rd_r;
	logic [SLOTS-1:0] flags_nxt;

	always_comb begin
		flags_nxt = flags_r;
		if (hw_clr)
			flags_nxt[hw_slot] = 1'b0;
		if (fw_clr)
			flags_nxt[fw_slot] = 1'b0;
		// firmware set wins over a clear in the same cycle
		if (fw_set)
			flags_nxt[fw_slot] = 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_r <= '0;
			rd_r    <= 1'b0;
		end else if (bus_rst) begin
			flags_r <= '0;
			rd_r    <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			rd_r    <= flags_nxt[rd_slot];
		end
	end

	assign rd_data = rd_r;
	assign flags   = flags_r;
endmodule
`default_nettype wire

// File: verilog/ebc_pkg.sv
// package: register map, field layout and types of the endpoint buffer control block
package ebc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] EBC_ADDR_CTRL  = 8'h28;
	localparam logic [7:0] EBC_ADDR_SEL   = 8'h2C;
	localparam logic [7:0] EBC_ADDR_STAT  = 8'h30;

	// ****************************************
	// control register fields
	// ****************************************
	localparam int EBC_BIT_FLUSH  = 4;
	localparam int EBC_BIT_COMMIT = 3;
	localparam int EBC_BIT_PERMIT = 2;
	localparam int EBC_BIT_STATUS = 1;
	localparam int EBC_BIT_STALL  = 0;
	localparam logic [7:0] EBC_CTRL_RST = 8'h00;

	// ****************************************
	// selector fields
	// ****************************************
	localparam int EBC_SEL_DIR    = 0;
	localparam int EBC_SEL_NUM_LO = 1;
	localparam int EBC_SEL_SETUP  = 5;
	localparam logic [7:0] EBC_SEL_RST = 8'h20;

	localparam int EBC_EP_NUM = 8;
	localparam int EBC_EP_W   = 4;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic [EBC_EP_W-1:0] num;
		logic                dir;
	} ebc_sel_t;

	typedef struct packed {
		logic stall;
		logic status_ack;
		logic permit;
	} ebc_ep_ctl_t;

	// link-side events for one endpoint
	typedef struct packed {
		logic                setup_tok;
		logic                status_done;
		logic                data_ack;
		logic [EBC_EP_W-1:0] ep;
	} ebc_link_evt_t;

	typedef enum logic [2:0] {
		EBC_ST_IDLE = 3'b001,
		EBC_ST_ACK  = 3'b010,
		EBC_ST_HOLD = 3'b100
	} ebc_bus_st_t;

	function automatic logic [EBC_EP_W:0] ebc_slot(input ebc_sel_t s);
		return {s.num, s.dir};
	endfunction

endpackage

// File: verilog/ebc_pulse_gen.sv
// one-cycle pulse register with endpoint slot tag, used for firmware commands
`timescale 1ns/1ps
`default_nettype none
module ebc_pulse_gen import ebc_pkg::*; #(
	parameter int W = EBC_EP_W + 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// request
	input  wire logic         fire,
	input  wire logic [W-1:0] slot,
	// pulse out
	output logic              pulse,
	output logic [W-1:0]      pulse_slot
);
	logic         pulse_r;
	logic [W-1:0] slot_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulse_r <= 1'b0;
			slot_r  <= '0;
		end else begin
			pulse_r <= fire;
			slot_r  <= fire ? slot : slot_r;
		end
	end

	assign pulse      = pulse_r;
	assign pulse_slot = slot_r;
endmodule
`default_nettype wire

// File: verilog/ebc_top.sv
// endpoint buffer control: indexed control register acting on the selected endpoint
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ebc_top import ebc_pkg::*; #(
	parameter int EP_NUM = EBC_EP_NUM
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                usb_bus_rst,
	// avalon-mm slave
	input  wire logic [7:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	// endpoint state from the buffer core
	input  wire logic [2*EP_NUM-1:0] ep_enabled,
	input  wire logic [2*EP_NUM-1:0] ep_isochronous,
	input  wire logic [2*EP_NUM-1:0] ep_full_packet,
	input  wire logic [2*EP_NUM-1:0] ep_rx_drained,
	// link events
	input  wire ebc_link_evt_t       link_evt,
	// commands to the buffer core
	output logic                     flush_pulse,
	output logic                     commit_pulse,
	output logic [EBC_EP_W:0]        cmd_slot,
	// control endpoint handshake policy and stall per endpoint slot
	output logic                     ctl_data_nak,
	output logic                     ctl_status_ack,
	output logic [2*EP_NUM-1:0]      ep_stalled
);
	localparam int SLOTS = 2*EP_NUM;
	localparam int SW    = $clog2(SLOTS);

	// ****************************************
	// registers
	// ****************************************
	ebc_sel_t    sel_r;
	logic        setup_sel_r;
	ebc_bus_st_t st_r;
	ebc_bus_st_t st_nxt;
	logic [31:0] rdata_r;
	logic        permit_r;
	logic        status_r;
	logic        wait_r;
	logic        dnak_r;
	logic        sack_r;
	logic [SLOTS-1:0] stall_o_r;

	// ****************************************
	// bus decode
	// ****************************************
	wire       req        = avs_read | avs_write;
	wire       take       = req && (st_r == EBC_ST_IDLE);
	wire       hit_ctrl   = avs_address == EBC_ADDR_CTRL;
	wire       hit_sel    = avs_address == EBC_ADDR_SEL;
	wire       hit_stat   = avs_address == EBC_ADDR_STAT;
	wire       wr_ctrl    = take && avs_write && hit_ctrl;
	wire       wr_sel     = take && avs_write && hit_sel;
	wire [SW-1:0] cur     = SW'(ebc_slot(sel_r));
	// endpoint numbers beyond the bank would alias onto a low slot
	wire       num_ok     = int'(sel_r.num) < EP_NUM;
	wire       cur_en     = num_ok && ep_enabled[cur] && !setup_sel_r;
	wire       act        = wr_ctrl && cur_en;
	wire       ctl_ep     = sel_r.num == '0;

	wire do_flush  = act && avs_writedata[EBC_BIT_FLUSH];
	wire do_commit = act && avs_writedata[EBC_BIT_COMMIT] && sel_r.dir;
	wire do_stall  = act && avs_writedata[EBC_BIT_STALL] && !ep_isochronous[cur];
	wire do_unstl  = act && !avs_writedata[EBC_BIT_STALL];
	wire set_perm  = act && ctl_ep && avs_writedata[EBC_BIT_PERMIT];
	wire wr_status = act && ctl_ep;

	// automatic flush and commit from the buffer core
	wire auto_flush  = |ep_rx_drained;
	wire auto_commit = |ep_full_packet;

	wire evt_ctl     = link_evt.ep == '0;
	wire clr_perm    = evt_ctl && (link_evt.data_ack || link_evt.setup_tok);
	wire clr_status  = evt_ctl && (link_evt.status_done || link_evt.setup_tok);

	logic stall_rd;
	logic [SLOTS-1:0] stall_flags;

	// ****************************************
	// stall flags per endpoint slot
	// ****************************************
	ebc_flag_bank #(
		.SLOTS (SLOTS)
	) u_stall (
		.clk     (clk),
		.rst     (rst),
		.bus_rst (usb_bus_rst),
		.fw_slot (cur),
		.fw_set  (do_stall),
		.fw_clr  (do_unstl),
		.hw_slot (cur),
		.hw_clr  (1'b0),
		.rd_slot (cur),
		.rd_data (stall_rd),
		.flags   (stall_flags)
	);

	// ****************************************
	// command pulses
	// ****************************************
	logic [EBC_EP_W:0] cmd_slot_r;
	logic              fl_p;
	logic              cm_p;

	ebc_pulse_gen #(
		.W (EBC_EP_W + 1)
	) u_flush (
		.clk        (clk),
		.rst        (rst),
		.fire       (do_flush),
		.slot       (ebc_slot(sel_r)),
		.pulse      (fl_p),
		.pulse_slot ()
	);

	ebc_pulse_gen #(
		.W (EBC_EP_W + 1)
	) u_commit (
		.clk        (clk),
		.rst        (rst),
		.fire       (do_commit),
		.slot       (ebc_slot(sel_r)),
		.pulse      (cm_p),
		.pulse_slot ()
	);

	// auto events are handled inside the buffer core; the slot register launches with the pulses
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cmd_slot_r <= '0;
		else if (do_flush || do_commit)
			cmd_slot_r <= ebc_slot(sel_r);
	end

	assign flush_pulse  = fl_p;
	assign commit_pulse = cm_p;
	assign cmd_slot     = cmd_slot_r;

	// ****************************************
	// bus state machine
	// ****************************************
	always_comb begin
		case (st_r)
			EBC_ST_IDLE: st_nxt = req ? EBC_ST_ACK : EBC_ST_IDLE;
			EBC_ST_ACK:  st_nxt = EBC_ST_HOLD;
			EBC_ST_HOLD: st_nxt = EBC_ST_IDLE;
			default:     st_nxt = EBC_ST_IDLE;
		endcase
	end

	// read data: permit reads zero in the control register, reserved bits zero
	wire [7:0] ctrl_rd = {3'h0, 1'b0, 1'b0, 1'b0,
		status_r && ctl_ep, stall_rd && num_ok};
	wire [7:0] sel_rd  = {2'h0, setup_sel_r, sel_r.num, sel_r.dir};
	wire [7:0] stat_rd = {5'h00, auto_commit, auto_flush, permit_r};
	wire [7:0] rd_mux  = hit_ctrl ? ctrl_rd :
	                     hit_sel  ? sel_rd  :
	                     hit_stat ? stat_rd : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r    <= EBC_ST_IDLE;
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			st_r    <= st_nxt;
			wait_r  <= !(st_nxt == EBC_ST_ACK);
			rdata_r <= (take && avs_read) ? {24'h00_0000, rd_mux} : rdata_r;
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata    = rdata_r;

	// ****************************************
	// selector register
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_r       <= '0;
			setup_sel_r <= EBC_SEL_RST[EBC_SEL_SETUP];
		end else if (usb_bus_rst) begin
			sel_r       <= '0;
		end else if (wr_sel) begin
			sel_r.num   <= avs_writedata[EBC_SEL_NUM_LO +: EBC_EP_W];
			sel_r.dir   <= avs_writedata[EBC_SEL_DIR];
			setup_sel_r <= avs_writedata[EBC_SEL_SETUP];
		end
	end

	// ****************************************
	// control endpoint permit and status
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			permit_r <= 1'b0;
			status_r <= 1'b0;
		end else if (usb_bus_rst) begin
			permit_r <= 1'b0;
			status_r <= 1'b0;
		end else begin
			// firmware write wins over a same-cycle hardware clear
			permit_r <= set_perm | (permit_r & ~clr_perm);
			status_r <= wr_status ? avs_writedata[EBC_BIT_STATUS]
			                      : (status_r & ~clr_status);
		end
	end

	// ****************************************
	// registered policy outputs
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dnak_r    <= 1'b1;
			sack_r    <= 1'b0;
			stall_o_r <= '0;
		end else begin
			dnak_r    <= !permit_r;
			sack_r    <= status_r;
			stall_o_r <= stall_flags;
		end
	end

	assign ctl_data_nak   = dnak_r;
	assign ctl_status_ack = sack_r;
	assign ep_stalled     = stall_o_r;
endmodule
`default_nettype wire
